// ### common/uie_pkg.sv
package uie_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SRC_N = 8;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MASK = 8'h00;
  localparam logic [7:0] ADDR_ID = 8'h04;
  localparam logic [7:0] ADDR_MODEM = 8'h08;

  // ----------------------------------------------------------------
  // Field positions of interrupt_mask
  // ----------------------------------------------------------------
  localparam int MB_RXDATA = 0;
  localparam int MB_THR = 1;
  localparam int MB_LINE = 2;
  localparam int MB_MODEM = 3;
  localparam int MB_SLEEP = 4;
  localparam int MB_XOFF = 5;
  localparam int MB_RTS = 6;
  localparam int MB_CTS = 7;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] MASK_LOCKED = 8'hF0;

  // ----------------------------------------------------------------
  // Pending source slots, slot 0 is the highest priority
  // ----------------------------------------------------------------
  localparam int SL_LINE = 0;
  localparam int SL_TIMEOUT = 1;
  localparam int SL_RXDATA = 2;
  localparam int SL_THR = 3;
  localparam int SL_MODEM = 4;
  localparam int SL_PIN = 5;
  localparam int SL_XOFF = 6;
  localparam int SL_FLOW = 7;

  // ----------------------------------------------------------------
  // Source codes in bits 5..0 of interrupt_source_id
  // ----------------------------------------------------------------
  localparam logic [5:0] CODE_LINE = 6'h06;
  localparam logic [5:0] CODE_TIMEOUT = 6'h0C;
  localparam logic [5:0] CODE_RXDATA = 6'h04;
  localparam logic [5:0] CODE_THR = 6'h02;
  localparam logic [5:0] CODE_MODEM = 6'h00;
  localparam logic [5:0] CODE_PIN = 6'h30;
  localparam logic [5:0] CODE_XOFF = 6'h10;
  localparam logic [5:0] CODE_FLOW = 6'h20;
  localparam logic [5:0] CODE_NONE = 6'h01;
  localparam logic [5:0] CODE_TAB [SRC_N] = '{CODE_LINE, CODE_TIMEOUT, CODE_RXDATA,
    CODE_THR, CODE_MODEM, CODE_PIN, CODE_XOFF, CODE_FLOW};

  // ----------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

endpackage

// ### src/uie_prio.sv
`timescale 1ns/1ns
module uie_prio
(
  input wire logic [7:0] pend,
  output logic [5:0] code
);

  // ----------------------------------------------------------------
  // Priority pick, walked from slot 7 down so slot 0 wins
  // ----------------------------------------------------------------
  always_comb
  begin
    code = uie_pkg::CODE_NONE;
    for (int i = uie_pkg::SRC_N - 1; i >= 0; i--)
    begin
      if (pend[i])
      begin
        code = uie_pkg::CODE_TAB[i];
      end
    end
  end

endmodule

// ### src/uie_top.sv
`timescale 1ns/1ns
// Functional notes
// R1: Seven interrupt kinds each have their own enable bit in interrupt_mask.
// R2: Any enabled pending source drives the interrupt request output active.
// R3: Mask bit 0 gates receive data interrupts.
// R4: Mask bit 1 gates the transmit holding interrupt.
// R5: Mask bit 2 gates the receiver line error interrupt.
// R6: Mask bit 3 gates the modem status interrupt.
// R7: Mask bit 4 requests sleep mode; zero leaves sleep off.
// R8: Mask bit 5 gates the Xoff received interrupt.
// R9: Mask bit 6 gates RTS change, bit 7 gates CTS change.
// R10: Reset clears the whole mask: all masked, sleep off.
// R11: Upper four mask bits only writable while enhanced write enable is set.
// R12: Re-enabling transmit interrupt alone never raises a new transmit interrupt.
// R13: Source id register is read-only 8 bits; writes do nothing.
// R14: Id bits 7 and 6 both mirror the FIFO enable bit.
// R15: Id bit 0 is 0 while something is pending, else 1.
// R16: Line error is top priority, code 000110.
// R17: Time-out 001100, rx data 000100, transmit 000010, modem 000000.
// R18: Input pin change is level 5, code 110000.
// R19: Xoff or special character is level 6, code 010000.
// R20: CTS or RTS going inactive high is level 7, code 100000.
// R21: Host reads modem status or pin state register to learn the cause.
// R22: Modem change flags set on input change, clear on modem status read.
// R23: Enabled special character match flags the Xoff/special source.
// R24: Highest pending enabled source is shown; request drops when none remain.
module uie_top
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic lineError,
  input wire logic rxTimeout,
  input wire logic rxDataReady,
  input wire logic txSpaceReady,
  input wire logic gpioPinChange,
  input wire logic xoffReceived,
  input wire logic specialCharMatch,
  input wire logic specialDetectEnable,
  input wire logic enhancedWriteEnable,
  input wire logic fifoEnableBit,
  input wire logic rtsOutN,
  input wire logic ctsPinN,
  input wire logic dsrPinN,
  input wire logic riPinN,
  input wire logic cdPinN,
  output logic irqN,
  output logic sleepRequest
);

  logic [7:0] interruptMask;
  logic awHeld;
  logic wHeld;
  logic [7:0] wrAddr;
  logic [7:0] wrData;
  logic wrLane0;
  logic doWrite;
  logic rdTake;
  logic idRead;
  logic modemRead;
  logic [3:0] pinMeta;
  logic [3:0] pinSync;
  logic [3:0] pinLast;
  logic rtsLast;
  logic txLast;
  logic [3:0] modemChg;
  logic [3:0] modemSet;
  logic thrFlag;
  logic xoffFlag;
  logic ctsFlag;
  logic rtsFlag;
  logic thrSet;
  logic xoffSet;
  logic ctsSet;
  logic rtsSet;
  logic [7:0] pend;
  logic [5:0] srcCode;
  logic [7:0] idValue;
  logic [7:0] modemValue;

  // ----------------------------------------------------------------
  // Write channel: address and data taken in either order
  // ----------------------------------------------------------------
  assign doWrite = awHeld && wHeld && !bvalid;

  // Address side, one write outstanding at a time
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awready <= 1'b0;
      awHeld <= 1'b0;
      wrAddr <= 8'h00;
    end
    else if (awvalid && awready)
    begin
      awready <= 1'b0;
      awHeld <= 1'b1;
      wrAddr <= awaddr;
    end
    else if (doWrite)
    begin
      awHeld <= 1'b0;
    end
    else if (!awHeld && !bvalid)
    begin
      awready <= 1'b1;
    end
  end

  // Data side, only the low lane carries register bits
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wready <= 1'b0;
      wHeld <= 1'b0;
      wrData <= 8'h00;
      wrLane0 <= 1'b0;
    end
    else if (wvalid && wready)
    begin
      wready <= 1'b0;
      wHeld <= 1'b1;
      wrData <= wdata[7:0];
      wrLane0 <= wstrb[0];
    end
    else if (doWrite)
    begin
      wHeld <= 1'b0;
    end
    else if (!wHeld && !bvalid)
    begin
      wready <= 1'b1;
    end
  end

  // Response; the id and modem registers accept and drop writes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bvalid <= 1'b0;
      bresp <= uie_pkg::RESP_OKAY;
    end
    else if (doWrite)
    begin
      bvalid <= 1'b1;
      if (wrAddr == uie_pkg::ADDR_MASK || wrAddr == uie_pkg::ADDR_ID || // R13
        wrAddr == uie_pkg::ADDR_MODEM)
      begin
        bresp <= uie_pkg::RESP_OKAY;
      end
      else
      begin
        bresp <= uie_pkg::RESP_SLVERR;
      end
    end
    else if (bvalid && bready)
    begin
      bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt mask register
  // ----------------------------------------------------------------
  // Upper nibble is locked unless enhanced writes are open
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      interruptMask <= uie_pkg::MASK_RESET; // R10
    end
    else if (doWrite && wrLane0 && wrAddr == uie_pkg::ADDR_MASK)
    begin
      if (enhancedWriteEnable)
      begin
        interruptMask <= wrData;
      end
      else
      begin
        interruptMask <= (interruptMask & uie_pkg::MASK_LOCKED) | // R11
          (wrData & ~uie_pkg::MASK_LOCKED);
      end
    end
  end

  // Sleep request follows the mask bit one cycle later
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sleepRequest <= 1'b0;
    end
    else
    begin
      sleepRequest <= interruptMask[uie_pkg::MB_SLEEP]; // R7
    end
  end

  // ----------------------------------------------------------------
  // Read channel, side effects happen at the address handshake
  // ----------------------------------------------------------------
  assign rdTake = arvalid && arready;
  assign idRead = rdTake && araddr == uie_pkg::ADDR_ID;
  assign modemRead = rdTake && araddr == uie_pkg::ADDR_MODEM;
  assign idValue = {fifoEnableBit, fifoEnableBit, srcCode}; // R14 R15
  // Live pin levels on top (active high), change flags below
  assign modemValue = {~pinSync, modemChg}; // R21

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= uie_pkg::DATA_ZERO;
      rresp <= uie_pkg::RESP_OKAY;
    end
    else if (rdTake)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= uie_pkg::RESP_OKAY;
      case (araddr)
        uie_pkg::ADDR_MASK: rdata <= {24'h00_0000, interruptMask};
        uie_pkg::ADDR_ID: rdata <= {24'h00_0000, idValue}; // R13
        uie_pkg::ADDR_MODEM: rdata <= {24'h00_0000, modemValue}; // R21
        default:
        begin
          rdata <= uie_pkg::DATA_ZERO;
          rresp <= uie_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
    end
    else if (!rvalid)
    begin
      arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Modem pins: two-flop synchronisers, then edge detection
  // ----------------------------------------------------------------
  // Bit order is CTS, DSR, RI, CD; pins are active low
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinMeta <= 4'hF;
      pinSync <= 4'hF;
      pinLast <= 4'hF;
    end
    else
    begin
      pinMeta <= {cdPinN, riPinN, dsrPinN, ctsPinN};
      pinSync <= pinMeta;
      pinLast <= pinSync;
    end
  end

  // RI reports only its low to high change, the rest any change
  assign modemSet = {pinSync[3] ^ pinLast[3], pinSync[2] & ~pinLast[2],
    pinSync[1] ^ pinLast[1], pinSync[0] ^ pinLast[0]};

  // Change flags; a new edge in the read cycle survives the clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      modemChg <= 4'h0;
    end
    else
    begin
      modemChg <= (modemRead ? 4'h0 : modemChg) | modemSet; // R22
    end
  end

  // ----------------------------------------------------------------
  // Event flags cleared by reading the id that names them
  // ----------------------------------------------------------------
  // Transmit flag arms only on the level edge, never on a mask write
  assign thrSet = txSpaceReady && !txLast; // R12
  assign xoffSet = xoffReceived || (specialCharMatch && specialDetectEnable); // R23
  assign ctsSet = pinSync[0] && !pinLast[0]; // R20
  assign rtsSet = rtsOutN && !rtsLast; // R20

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txLast <= 1'b0;
      rtsLast <= 1'b1;
    end
    else
    begin
      txLast <= txSpaceReady;
      rtsLast <= rtsOutN;
    end
  end

  // Set wins over clear when both land together
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      thrFlag <= 1'b0;
      xoffFlag <= 1'b0;
      ctsFlag <= 1'b0;
      rtsFlag <= 1'b0;
    end
    else
    begin
      thrFlag <= thrSet || (thrFlag && !(idRead && srcCode == uie_pkg::CODE_THR));
      xoffFlag <= xoffSet || (xoffFlag && !(idRead && srcCode == uie_pkg::CODE_XOFF));
      ctsFlag <= ctsSet || (ctsFlag && !(idRead && srcCode == uie_pkg::CODE_FLOW));
      rtsFlag <= rtsSet || (rtsFlag && !(idRead && srcCode == uie_pkg::CODE_FLOW));
    end
  end

  // ----------------------------------------------------------------
  // Masked pending sources and priority pick
  // ----------------------------------------------------------------
  assign pend[uie_pkg::SL_LINE] = lineError && interruptMask[uie_pkg::MB_LINE]; // R5 R1
  assign pend[uie_pkg::SL_TIMEOUT] = rxTimeout && interruptMask[uie_pkg::MB_RXDATA]; // R3
  assign pend[uie_pkg::SL_RXDATA] = rxDataReady && interruptMask[uie_pkg::MB_RXDATA]; // R3
  assign pend[uie_pkg::SL_THR] = thrFlag && interruptMask[uie_pkg::MB_THR]; // R4
  assign pend[uie_pkg::SL_MODEM] = (|modemChg) && interruptMask[uie_pkg::MB_MODEM]; // R6
  assign pend[uie_pkg::SL_PIN] = gpioPinChange && interruptMask[uie_pkg::MB_MODEM]; // R6
  assign pend[uie_pkg::SL_XOFF] = xoffFlag && interruptMask[uie_pkg::MB_XOFF]; // R8
  assign pend[uie_pkg::SL_FLOW] = (ctsFlag && interruptMask[uie_pkg::MB_CTS]) || // R9
    (rtsFlag && interruptMask[uie_pkg::MB_RTS]);

  // Fixed table keeps codes in one place, shared with the id read
  uie_prio u_prio
  (
    .pend(pend),
    .code(srcCode) // R16 R17 R18 R19 R24
  );

  // Request line, active low, registered to stay glitch free
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irqN <= 1'b1;
    end
    else
    begin
      irqN <= !(|pend); // R2 R24
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_idRead;
    arvalid && arready && araddr == uie_pkg::ADDR_ID;
  endsequence

  sequence s_maskWriteLocked;
    doWrite && wrLane0 && wrAddr == uie_pkg::ADDR_MASK && !enhancedWriteEnable;
  endsequence

  property p_upper_locked;
    s_maskWriteLocked |=> interruptMask[7:4] == $past(interruptMask[7:4]);
  endproperty
  a_upper_locked: assert property (p_upper_locked) else $error("locked mask bits changed"); // R11

  property p_irq_on;
    (|pend) |=> !irqN;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("request not raised"); // R2

  property p_irq_off;
    !(|pend) |=> irqN;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("request not dropped"); // R24

  property p_thr_norefire;
    $rose(interruptMask[uie_pkg::MB_THR]) && !thrFlag && !thrSet |=> !thrFlag;
  endproperty
  a_thr_norefire: assert property (p_thr_norefire) else $error("transmit refired"); // R12

  property p_id_status;
    s_idRead ##1 rvalid |-> rdata[0] == !(|$past(pend));
  endproperty
  a_id_status: assert property (p_id_status) else $error("id bit 0 wrong"); // R15

  property p_id_mirror;
    s_idRead |=> rdata[7:6] == {2{$past(fifoEnableBit)}};
  endproperty
  a_id_mirror: assert property (p_id_mirror) else $error("id mirror wrong"); // R14

  property p_line_top;
    s_idRead and pend[uie_pkg::SL_LINE] |=> rdata[5:0] == uie_pkg::CODE_LINE;
  endproperty
  a_line_top: assert property (p_line_top) else $error("line error not on top"); // R16

  property p_pin_code;
    s_idRead and (pend[5] && !(|pend[4:0])) |=> rdata[5:0] == uie_pkg::CODE_PIN;
  endproperty
  a_pin_code: assert property (p_pin_code) else $error("pin change code wrong"); // R18

  property p_sleep;
    interruptMask[uie_pkg::MB_SLEEP] ##1 interruptMask[uie_pkg::MB_SLEEP] |-> sleepRequest;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not requested"); // R7

  property p_modem_clear;
    modemRead && !(|modemSet) |=> modemChg == 4'h0;
  endproperty
  a_modem_clear: assert property (p_modem_clear) else $error("modem flags kept"); // R22

endmodule

// ### dv/uie_host_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Host side of the register bus
// ----------------------------------------
module uie_host_model
(
  input wire logic clk,
  output logic awvalid,
  input wire logic awready,
  output logic [7:0] awaddr,
  output logic wvalid,
  input wire logic wready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] bresp,
  output logic arvalid,
  input wire logic arready,
  output logic [7:0] araddr,
  input wire logic rvalid,
  output logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp
);
  // Idle bus from time zero
  initial
  begin
    awvalid = 1'b0;
    awaddr = 8'h00;
    wvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    bready = 1'b0;
    arvalid = 1'b0;
    araddr = 8'h00;
    rready = 1'b0;
  end

  // Address and data offered together; each dropped alone once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [1:0] resp);
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (!(bvalid && bready));
    resp = bresp;
    bready <= 1'b0;
  endtask

  // No latency assumed; the bench watchdog ends a hang
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (!(rvalid && rready));
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
endmodule

// ### dv/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irqN, sleepRequest;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rdat;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic lineError, rxTimeout, rxDataReady, txSpaceReady, gpioPinChange, xoffReceived;
  logic specialCharMatch, specialDetectEnable, enhancedWriteEnable, fifoEnableBit;
  logic rtsOutN, ctsPinN, dsrPinN, riPinN, cdPinN;
  int num_errors = 0;
  int comparisons = 0;

  uie_top dut (.clk, .rst_n, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
    .lineError, .rxTimeout, .rxDataReady, .txSpaceReady, .gpioPinChange, .xoffReceived,
    .specialCharMatch, .specialDetectEnable, .enhancedWriteEnable, .fifoEnableBit,
    .rtsOutN, .ctsPinN, .dsrPinN, .riPinN, .cdPinN, .irqN, .sleepRequest);

  uie_host_model u_host (.clk, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
    .rdata, .rresp);

  // 100 ns period
  always #50 clk = ~clk;

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wmask(input logic [7:0] m);
    u_host.wr(uie_pkg::ADDR_MASK, {24'h00_0000, m}, 4'hF, resp);
  endtask

  task automatic mask_is(input logic [7:0] m);
    u_host.rd(uie_pkg::ADDR_MASK, rdat, resp);
    check("mask", rdat, {24'h00_0000, m});
  endtask

  // Irq line sampled before the read, since the read may clear event flags;
  // pin changes need two sync flops, one edge flop and the request flop
  task automatic id_is(input logic [5:0] code);
    step(5);
    check("irqN", 32'(irqN), 32'(code == uie_pkg::CODE_NONE));
    u_host.rd(uie_pkg::ADDR_ID, rdat, resp);
    check("source id", rdat, {24'h00_0000, fifoEnableBit, fifoEnableBit, code});
  endtask

  task automatic final_report();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    step(20000);
    num_errors++;
    final_report();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    {lineError, rxTimeout, rxDataReady, txSpaceReady, gpioPinChange, xoffReceived} = 6'h00;
    {specialCharMatch, specialDetectEnable, enhancedWriteEnable, fifoEnableBit} = 4'h0;
    {rtsOutN, ctsPinN, dsrPinN, riPinN, cdPinN} = 5'h1F;
    step(8);
    rst_n <= 1'b1;
    step(2);
    mask_is(8'h00);
    check("sleep", 32'(sleepRequest), 32'h0000_0000);
    id_is(uie_pkg::CODE_NONE);
    // Upper bits locked, strobe off writes nothing
    wmask(8'hFF);
    mask_is(8'h0F);
    u_host.wr(uie_pkg::ADDR_MASK, 32'h0000_0000, 4'h0, resp);
    mask_is(8'h0F);
    enhancedWriteEnable <= 1'b1;
    wmask(8'h10);
    step(2);
    check("sleep", 32'(sleepRequest), 32'h0000_0001);
    wmask(8'h00);
    step(2);
    check("sleep", 32'(sleepRequest), 32'h0000_0000);
    // Priority walk over the level sources
    fifoEnableBit <= 1'b1;
    wmask(8'hFB);
    {lineError, rxTimeout, rxDataReady, gpioPinChange} <= 4'hF;
    id_is(uie_pkg::CODE_TIMEOUT);
    wmask(8'hFF);
    id_is(uie_pkg::CODE_LINE);
    lineError <= 1'b0;
    id_is(uie_pkg::CODE_TIMEOUT);
    rxTimeout <= 1'b0;
    id_is(uie_pkg::CODE_RXDATA);
    rxDataReady <= 1'b0;
    id_is(uie_pkg::CODE_PIN);
    wmask(8'hF7);
    id_is(uie_pkg::CODE_NONE);
    gpioPinChange <= 1'b0;
    rxDataReady <= 1'b1;
    wmask(8'hFE);
    id_is(uie_pkg::CODE_NONE);
    rxDataReady <= 1'b0;
    // Transmit event needs a rising space level
    wmask(8'hFD);
    wmask(8'hFF);
    id_is(uie_pkg::CODE_NONE);
    txSpaceReady <= 1'b1;
    id_is(uie_pkg::CODE_THR);
    id_is(uie_pkg::CODE_NONE);
    txSpaceReady <= 1'b0;
    // Pulse sources, cleared by the id read
    xoffReceived <= 1'b1;
    step(1);
    xoffReceived <= 1'b0;
    id_is(uie_pkg::CODE_XOFF);
    id_is(uie_pkg::CODE_NONE);
    specialDetectEnable <= 1'b1;
    specialCharMatch <= 1'b1;
    step(1);
    specialCharMatch <= 1'b0;
    id_is(uie_pkg::CODE_XOFF);
    rtsOutN <= 1'b0;
    step(2);
    rtsOutN <= 1'b1;
    id_is(uie_pkg::CODE_FLOW);
    id_is(uie_pkg::CODE_NONE);
    // Modem lines: change flags, then flow event behind the modem source
    {ctsPinN, dsrPinN} <= 2'h0;
    id_is(uie_pkg::CODE_MODEM);
    u_host.rd(uie_pkg::ADDR_MODEM, rdat, resp);
    check("modem", rdat, 32'h0000_0033);
    id_is(uie_pkg::CODE_NONE);
    ctsPinN <= 1'b1;
    id_is(uie_pkg::CODE_MODEM);
    u_host.rd(uie_pkg::ADDR_MODEM, rdat, resp);
    check("modem", rdat, 32'h0000_0021);
    id_is(uie_pkg::CODE_FLOW);
    id_is(uie_pkg::CODE_NONE);
    // Dropped and refused accesses
    u_host.wr(uie_pkg::ADDR_ID, 32'h0000_00FF, 4'hF, resp);
    check("id write resp", 32'(resp), 32'(uie_pkg::RESP_OKAY));
    id_is(uie_pkg::CODE_NONE);
    u_host.rd(8'h0C, rdat, resp);
    check("unmapped read", rdat, uie_pkg::DATA_ZERO);
    check("unmapped rresp", 32'(resp), 32'(uie_pkg::RESP_SLVERR));
    u_host.wr(8'h0C, 32'h0000_0000, 4'hF, resp);
    check("unmapped bresp", 32'(resp), 32'(uie_pkg::RESP_SLVERR));
    enhancedWriteEnable <= 1'b0;
    wmask(8'h00);
    mask_is(8'hF0);
    final_report();
  end
endmodule
